// File: logic/swcsm_consts.svh
// Constants for the single-wire configuration and status message handler.
`ifndef SWCSM_CONSTS_SVH
`define SWCSM_CONSTS_SVH
`define SWCSM_CLK_HZ 32'h0262_5A00
`define SWCSM_BAUD 32'h0000_2580
`define SWCSM_US_HZ 32'h000F_4240
`define SWCSM_TOUT_US 32'h0000_1388
`define SWCSM_BIT_CYC (`SWCSM_CLK_HZ / `SWCSM_BAUD)
`define SWCSM_TOUT_CYC (`SWCSM_CLK_HZ / `SWCSM_US_HZ * `SWCSM_TOUT_US)
`define SWCSM_CMD_WR_CFG0 8'h81
`define SWCSM_CMD_RD_CFG0 8'h82
`define SWCSM_CMD_WR_CFG1 8'h83
`define SWCSM_CMD_RD_CFG1 8'h84
`define SWCSM_CMD_RD_STATUS_REGISTER_ZERO 8'h85
`define SWCSM_CMD_RD_STATUS_REGISTER_ONE 8'h86
`define SWCSM_CMD_WR_CFG2 8'h87
`define SWCSM_CMD_RD_CFG2 8'h88
`define SWCSM_CMD_BIT 7
`define SWCSM_ACK_BIT 6
`define SWCSM_CMD_RSV_HI 6
`define SWCSM_CMD_RSV_LO 5
`define SWCSM_CFG0_RSV 7
`define SWCSM_CFG0_PULLUP 6
`define SWCSM_CFG0_SLEEP 5
`define SWCSM_CFG0_NSIM 4
`define SWCSM_CFG0_UVLO 3
`define SWCSM_CFG0_SCD 2
`define SWCSM_CFG0_OC_HI 1
`define SWCSM_CFG0_OC_LO 0
`define SWCSM_CFG0_RST 8'h00
`define SWCSM_CFG1_RST 8'h40
`define SWCSM_CFG2_RST 8'h00
`define SWCSM_CFG2_MASK 8'h1F
`define SWCSM_BROWNOUT_RESTART_FLAG_BIT 0
`endif

// File: logic/swcsm_pkg.sv
// Types shared by the message handler files.
package swcsm_pkg;
	typedef enum {ST_IDLE, ST_WAIT_DATA, ST_SEND_FIRST, ST_SEND_SECOND} swcsm_state_type;
	typedef enum {SRC_PLAIN, SRC_STATUS_REGISTER_ZERO, SRC_STATUS_REGISTER_ONE, SRC_UNSOL} swcsm_src_type;
endpackage : swcsm_pkg

// File: logic/swcsm_byte_if.sv
// Byte stream between the message core and the serial framer.
`timescale 1ns/1ps
interface swcsm_byte_if;
	logic rx_valid;
	logic [7:0] rx_data;
	logic tx_valid;
	logic tx_ready;
	logic [7:0] tx_data;
	modport framer (output rx_valid, output rx_data, input tx_valid, output tx_ready,
		input tx_data);
	modport core (input rx_valid, input rx_data, output tx_valid, input tx_ready,
		output tx_data);
endinterface : swcsm_byte_if

// File: logic/swcsm_uart.sv
// Half-duplex open-drain byte framer: start bit, eight data bits LSB first, stop bit.
`timescale 1ns/1ps
module swcsm_uart #(
	parameter int BIT_CYCLES = 4166
) (
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic line_in,
	output logic line_oe_out,
	swcsm_byte_if.framer bus
);
	localparam int CW = $clog2(BIT_CYCLES + 1);
	logic prev_q;
	logic rx_busy_q;
	logic [CW-1:0] rx_cnt_q;
	logic [3:0] rx_idx_q;
	logic [7:0] rx_sh_q;
	logic rx_valid_q;
	logic tx_busy_q;
	logic [CW-1:0] tx_cnt_q;
	logic [3:0] tx_idx_q;
	logic [9:0] tx_sh_q;
	logic oe_q;

	generate
		if (BIT_CYCLES < 4) begin : g_chk
			$error("BIT_CYCLES too small");
		end
	endgenerate

	// Receiving is held off while transmitting, since the own bits echo on the shared line.
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			prev_q <= 1'b1;
			rx_busy_q <= 1'b0;
			rx_cnt_q <= '0;
			rx_idx_q <= 4'h0;
			rx_sh_q <= 8'h00;
			rx_valid_q <= 1'b0;
		end else begin
			prev_q <= line_in;
			rx_valid_q <= 1'b0;
			if (!rx_busy_q) begin
				if (!tx_busy_q && prev_q && !line_in) begin // [RL26]
					rx_busy_q <= 1'b1;
					rx_cnt_q <= CW'(BIT_CYCLES / 2);
					rx_idx_q <= 4'h0;
				end
			end else if (rx_cnt_q != '0) begin
				rx_cnt_q <= rx_cnt_q - 1'b1;
			end else begin
				rx_cnt_q <= CW'(BIT_CYCLES - 1);
				rx_idx_q <= rx_idx_q + 4'h1;
				if (rx_idx_q == 4'h0 && line_in) begin
					rx_busy_q <= 1'b0;
				end else if (rx_idx_q == 4'h9) begin
					rx_busy_q <= 1'b0;
					rx_valid_q <= line_in; // [RL26]
				end else if (rx_idx_q != 4'h0) begin
					rx_sh_q <= {line_in, rx_sh_q[7:1]};
				end
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tx_busy_q <= 1'b0;
			tx_cnt_q <= '0;
			tx_idx_q <= 4'h0;
			tx_sh_q <= 10'h3FF;
			oe_q <= 1'b0;
		end else if (!tx_busy_q) begin
			if (bus.tx_valid && !rx_busy_q) begin
				tx_busy_q <= 1'b1;
				tx_sh_q <= {1'b1, bus.tx_data, 1'b0}; // [RL26]
				tx_cnt_q <= CW'(BIT_CYCLES - 1);
				tx_idx_q <= 4'h0;
				oe_q <= 1'b1;
			end
		end else if (tx_cnt_q != '0) begin
			tx_cnt_q <= tx_cnt_q - 1'b1;
		end else begin
			tx_cnt_q <= CW'(BIT_CYCLES - 1);
			tx_idx_q <= tx_idx_q + 4'h1;
			tx_sh_q <= {1'b1, tx_sh_q[9:1]};
			oe_q <= ~tx_sh_q[1];
			if (tx_idx_q == 4'h9) begin
				tx_busy_q <= 1'b0;
				oe_q <= 1'b0;
			end
		end
	end

	assign bus.tx_ready = !tx_busy_q && !rx_busy_q;
	assign bus.rx_valid = rx_valid_q;
	assign bus.rx_data = rx_sh_q;
	assign line_oe_out = oe_q;
endmodule : swcsm_uart

// File: logic/swcsm_top.sv
// Command interpreter and status messenger behind the single-wire message port.
// Function
// RL1: Response echoes command byte, bit 7 cleared, bit 6 one for ACK, zero for NACK.
// RL2: Returned data follows immediately as the second response byte.
// RL3: Unsupported or failing commands get a NACK response.
// RL4: Unsolicited messages never wait for any host reply.
// RL5: Host may write configuration any time and keeps the system safe itself.
// RL6: Status requests return the matching status register as ACK data.
// RL7: Unsolicited status message only when a status bit turns active.
// RL8: Reported fault clears on matching status request or chip enable low then high.
// RL9: A fault still present at clear time stays active.
// RL10: Brown-out restart flag sets on every restart.
// RL11: Setting the restart flag sends exactly one unsolicited message.
// RL12: Restart flag clears only when a status-1 ACK is sent.
// RL13: Configuration-0 write is byte 81 hex followed by one data byte.
// RL14: Configuration-0 bit 6 selects pull-up disconnect; reads zero in sleep.
// RL15: Configuration-0 bit 5 picks standby or sleep; sleep forces disconnect.
// RL16: Configuration-0 bit 4 enables the neutral-point simulator, default off.
// RL17: Configuration-0 bit 3 disables transistor undervoltage lockout, default enabled.
// RL18: Configuration-0 bit 2 disables short-circuit detection, default enabled.
// RL19: Configuration-0 bits 1:0 pick the overcurrent threshold, default 0.250 V.
// RL20: Configuration-0 read returns the register as ACK data.
// RL21: Configuration-1 write loads the current-limit reference; its read returns it.
// RL22: Configuration-2 write loads timing; its read returns the register.
// RL23: Command bytes have bit 7 set, bits 6 and 5 zero, code in 4:0.
// RL24: Missing second byte of a two-byte command yields NACK after 5 ms.
// RL25: Answer commands only with chip enable low; never initiate while low.
// RL26: Bytes travel as start bit, eight data bits, stop bit at 9600 baud.
// RL27: Configuration-0 bit 7 is ignored on write and reads zero.
`timescale 1ns/1ps
`include "swcsm_consts.svh"
module swcsm_top #(
	parameter int BIT_CYCLES = `SWCSM_BIT_CYC,
	parameter int TIMEOUT_CYCLES = `SWCSM_TOUT_CYC
) (
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic line_in,
	output logic line_out,
	output logic line_oe_out,
	input wire logic chip_enable_in,
	input wire logic sleep_mode_in,
	input wire logic restart_in,
	input wire logic [7:0] fault0_in,
	input wire logic [6:0] fault1_in,
	output logic [7:0] config_register_zero_out,
	output logic [7:0] current_ref_out,
	output logic [7:0] timing_cfg_out,
	output logic [7:0] status_register_zero_out,
	output logic [7:0] status_register_one_out
);
	localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
	localparam logic [TW-1:0] TOUT_LAST = TW'(TIMEOUT_CYCLES - 1);

	swcsm_byte_if bif ();
	swcsm_pkg::swcsm_state_type state_q;
	swcsm_pkg::swcsm_src_type src_q;
	logic [7:0] cmd_q;
	logic [7:0] resp0_q;
	logic [7:0] resp1_q;
	logic two_q;
	logic [TW-1:0] timer_q;
	logic [7:0] cfg0_q;
	logic [7:0] cfg1_q;
	logic [7:0] cfg2_q;
	logic [7:0] status_register_zero_q;
	logic [7:0] status_register_one_q;
	logic pend0_q;
	logic pend1_q;
	logic ce_q;
	logic take_first;
	logic take_second;
	logic ce_rise;
	logic cmd_ok;
	logic start_unsol0;
	logic start_unsol1;
	logic clr0;
	logic clr1;
	logic brownout_restart_flag_clr;
	logic [7:0] cfg0_rd;
	logic [7:0] ack_byte;
	logic [7:0] nack_byte;

	generate
		if (TIMEOUT_CYCLES < 1 || BIT_CYCLES < 4) begin : g_chk
			$error("Cycle counts too small");
		end
	endgenerate

	swcsm_uart #(.BIT_CYCLES(BIT_CYCLES)) u_uart (
		.ref_clk_in(ref_clk_in),
		.rstn_in(rstn_in),
		.line_in(line_in),
		.line_oe_out(line_oe_out),
		.bus(bif.framer)
	);

	assign line_out = 1'b0;
	assign take_first = (state_q == swcsm_pkg::ST_SEND_FIRST) && bif.tx_ready;
	assign take_second = (state_q == swcsm_pkg::ST_SEND_SECOND) && bif.tx_ready;
	assign bif.tx_valid = (state_q == swcsm_pkg::ST_SEND_FIRST) ||
		(state_q == swcsm_pkg::ST_SEND_SECOND);
	assign bif.tx_data = (state_q == swcsm_pkg::ST_SEND_SECOND) ? resp1_q : resp0_q;
	assign ce_rise = chip_enable_in && !ce_q;
	assign cmd_ok = bif.rx_data[`SWCSM_CMD_BIT] && !bif.rx_data[`SWCSM_CMD_RSV_HI] &&
		!bif.rx_data[`SWCSM_CMD_RSV_LO]; // [RL23]
	assign ack_byte = {1'b0, 1'b1, bif.rx_data[5:0]}; // [RL1]
	assign nack_byte = {1'b0, 1'b0, bif.rx_data[5:0]}; // [RL1]

	// Sleep hides the pull-up choice, since sleep always disconnects the pull-up.
	always_comb begin
		cfg0_rd = cfg0_q;
		if (sleep_mode_in) begin
			cfg0_rd[`SWCSM_CFG0_PULLUP] = 1'b0; // [RL14] [RL15]
		end
	end

	// Unsolicited messages only start with chip enable high and the engine idle.
	assign start_unsol1 = (state_q == swcsm_pkg::ST_IDLE) && chip_enable_in &&
		!bif.rx_valid && pend1_q; // [RL25]
	assign start_unsol0 = (state_q == swcsm_pkg::ST_IDLE) && chip_enable_in &&
		!bif.rx_valid && !pend1_q && pend0_q; // [RL25]
	assign clr0 = (take_first && src_q == swcsm_pkg::SRC_STATUS_REGISTER_ZERO) || ce_rise; // [RL8]
	assign clr1 = (take_first && src_q == swcsm_pkg::SRC_STATUS_REGISTER_ONE) || ce_rise; // [RL8]
	assign brownout_restart_flag_clr = take_first && src_q == swcsm_pkg::SRC_STATUS_REGISTER_ONE; // [RL12]

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_q <= swcsm_pkg::ST_IDLE;
			src_q <= swcsm_pkg::SRC_PLAIN;
			cmd_q <= 8'h00;
			resp0_q <= 8'h00;
			resp1_q <= 8'h00;
			two_q <= 1'b0;
			timer_q <= '0;
		end else begin
			case (state_q)
				swcsm_pkg::ST_IDLE: begin
					if (bif.rx_valid && !chip_enable_in && bif.rx_data[`SWCSM_CMD_BIT]) begin // [RL25]
						cmd_q <= bif.rx_data;
						src_q <= swcsm_pkg::SRC_PLAIN;
						resp0_q <= ack_byte;
						two_q <= 1'b1;
						state_q <= swcsm_pkg::ST_SEND_FIRST;
						case (cmd_ok ? bif.rx_data : 8'h00)
							`SWCSM_CMD_WR_CFG0, `SWCSM_CMD_WR_CFG1, `SWCSM_CMD_WR_CFG2: begin
								timer_q <= '0;
								state_q <= swcsm_pkg::ST_WAIT_DATA; // [RL13]
							end
							`SWCSM_CMD_RD_CFG0: begin
								resp1_q <= cfg0_rd; // [RL20]
							end
							`SWCSM_CMD_RD_CFG1: begin
								resp1_q <= cfg1_q; // [RL21]
							end
							`SWCSM_CMD_RD_CFG2: begin
								resp1_q <= cfg2_q; // [RL22]
							end
							`SWCSM_CMD_RD_STATUS_REGISTER_ZERO: begin
								resp1_q <= status_register_zero_q; // [RL6]
								src_q <= swcsm_pkg::SRC_STATUS_REGISTER_ZERO;
							end
							`SWCSM_CMD_RD_STATUS_REGISTER_ONE: begin
								resp1_q <= status_register_one_q; // [RL6]
								src_q <= swcsm_pkg::SRC_STATUS_REGISTER_ONE;
							end
							default: begin
								resp0_q <= nack_byte; // [RL3]
								two_q <= 1'b0;
							end
						endcase
					end else if (start_unsol1) begin
						resp0_q <= `SWCSM_CMD_RD_STATUS_REGISTER_ONE & 8'h7F | 8'h40; // [RL11]
						resp1_q <= status_register_one_q;
						two_q <= 1'b1;
						src_q <= swcsm_pkg::SRC_UNSOL;
						state_q <= swcsm_pkg::ST_SEND_FIRST;
					end else if (start_unsol0) begin
						resp0_q <= `SWCSM_CMD_RD_STATUS_REGISTER_ZERO & 8'h7F | 8'h40; // [RL7]
						resp1_q <= status_register_zero_q;
						two_q <= 1'b1;
						src_q <= swcsm_pkg::SRC_UNSOL;
						state_q <= swcsm_pkg::ST_SEND_FIRST;
					end
				end
				swcsm_pkg::ST_WAIT_DATA: begin
					two_q <= 1'b0;
					if (bif.rx_valid) begin
						resp0_q <= {1'b0, 1'b1, cmd_q[5:0]}; // [RL1]
						state_q <= swcsm_pkg::ST_SEND_FIRST;
					end else if (timer_q == TOUT_LAST) begin
						resp0_q <= {1'b0, 1'b0, cmd_q[5:0]}; // [RL24]
						state_q <= swcsm_pkg::ST_SEND_FIRST;
					end else begin
						timer_q <= timer_q + 1'b1;
					end
				end
				swcsm_pkg::ST_SEND_FIRST: begin
					if (bif.tx_ready) begin
						state_q <= two_q ? swcsm_pkg::ST_SEND_SECOND : swcsm_pkg::ST_IDLE; // [RL2]
					end
				end
				swcsm_pkg::ST_SEND_SECOND: begin
					if (bif.tx_ready) begin
						state_q <= swcsm_pkg::ST_IDLE; // [RL4]
					end
				end
				default: begin
					state_q <= swcsm_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Writes are accepted whatever the motor state; the host owns that hazard.
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cfg0_q <= `SWCSM_CFG0_RST; // [RL16] [RL17] [RL18] [RL19]
			cfg1_q <= `SWCSM_CFG1_RST;
			cfg2_q <= `SWCSM_CFG2_RST;
		end else if (state_q == swcsm_pkg::ST_WAIT_DATA && bif.rx_valid) begin // [RL5]
			if (cmd_q == `SWCSM_CMD_WR_CFG0) begin
				cfg0_q <= bif.rx_data & 8'h7F; // [RL27] [RL14] [RL15]
			end
			if (cmd_q == `SWCSM_CMD_WR_CFG1) begin
				cfg1_q <= bif.rx_data; // [RL21]
			end
			if (cmd_q == `SWCSM_CMD_WR_CFG2) begin
				cfg2_q <= bif.rx_data & `SWCSM_CFG2_MASK; // [RL22]
			end
		end
	end

	// A live fault re-sets its bit in the same cycle as the clear, so it cannot be lost.
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ce_q <= 1'b0;
			status_register_zero_q <= 8'h00;
			status_register_one_q <= 8'h01;
		end else begin
			ce_q <= chip_enable_in;
			status_register_zero_q <= (clr0 ? 8'h00 : status_register_zero_q) | fault0_in; // [RL8] [RL9]
			status_register_one_q[7:1] <= (clr1 ? 7'h00 : status_register_one_q[7:1]) | fault1_in; // [RL8] [RL9]
			status_register_one_q[`SWCSM_BROWNOUT_RESTART_FLAG_BIT] <= (status_register_one_q[`SWCSM_BROWNOUT_RESTART_FLAG_BIT] && !brownout_restart_flag_clr) ||
				restart_in; // [RL10] [RL12]
		end
	end

	// The status-1 pending message starts set for the power-up report, so one is sent after reset.
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pend0_q <= 1'b0;
			pend1_q <= 1'b1;
		end else begin
			pend0_q <= (pend0_q && !start_unsol0) || |(fault0_in & ~status_register_zero_q); // [RL7]
			pend1_q <= (pend1_q && !start_unsol1) || |(fault1_in & ~status_register_one_q[7:1]) ||
				(restart_in && !status_register_one_q[`SWCSM_BROWNOUT_RESTART_FLAG_BIT]); // [RL7] [RL11]
		end
	end

	assign config_register_zero_out = cfg0_q;
	assign current_ref_out = cfg1_q;
	assign timing_cfg_out = cfg2_q;
	assign status_register_zero_out = status_register_zero_q;
	assign status_register_one_out = status_register_one_q;

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rstn_in);

	AST_ECHO: assert property (take_first && src_q != swcsm_pkg::SRC_UNSOL |->
		!bif.tx_data[7] && bif.tx_data[4:0] == cmd_q[4:0]) // [RL1]
		else $error("response does not echo the command");
	AST_DATA_NEXT: assert property (take_first && two_q |=>
		state_q == swcsm_pkg::ST_SEND_SECOND && bif.tx_data == resp1_q) // [RL2]
		else $error("data byte does not follow echo");
	AST_UNSUP_NACK: assert property (state_q == swcsm_pkg::ST_IDLE && bif.rx_valid &&
		!chip_enable_in && bif.rx_data[7] && !cmd_ok |=> !resp0_q[6] && !two_q) // [RL3]
		else $error("bad command not refused");
	AST_STATUS_REGISTER_ONE_DATA: assert property (state_q == swcsm_pkg::ST_IDLE && bif.rx_valid &&
		!chip_enable_in && bif.rx_data == `SWCSM_CMD_RD_STATUS_REGISTER_ONE |=>
		resp1_q == $past(status_register_one_q) && resp0_q == 8'h46) // [RL6]
		else $error("status one not returned");
	AST_BROWNOUT_RESTART_FLAG_FALL: assert property ($fell(status_register_one_q[`SWCSM_BROWNOUT_RESTART_FLAG_BIT]) |->
		$past(brownout_restart_flag_clr)) // [RL12]
		else $error("restart flag cleared without status one ack");
	AST_FAULT_HOLD: assert property (fault0_in[0] |=> status_register_zero_q[0]) // [RL9]
		else $error("live fault was cleared");
	AST_NO_INIT_CE_LOW: assert property (!chip_enable_in && state_q == swcsm_pkg::ST_IDLE
		|=> src_q != swcsm_pkg::SRC_UNSOL || state_q == swcsm_pkg::ST_IDLE) // [RL25]
		else $error("message initiated with chip enable low");
	AST_TIMEOUT_NACK: assert property (state_q == swcsm_pkg::ST_WAIT_DATA &&
		timer_q == TOUT_LAST && !bif.rx_valid |=>
		state_q == swcsm_pkg::ST_SEND_FIRST && !resp0_q[6] && !two_q) // [RL24]
		else $error("missing data byte not refused at timeout");
	AST_CFG0_RSV: assert property (!config_register_zero_out[`SWCSM_CFG0_RSV]) // [RL27]
		else $error("reserved bit set");
	AST_UNSOL_ONCE: assert property (start_unsol1 |=> !pend1_q ||
		$past(restart_in) || $past(|fault1_in)) // [RL11]
		else $error("unsolicited restart report repeated");
endmodule : swcsm_top

// File: testbench/swcsm_host_model.sv
// Host partner model on the open-drain single-wire message line.
`timescale 1ns/1ps
module swcsm_host_model #(
	parameter int BIT_CYCLES = 8
) (
	input wire logic ref_clk_in,
	input wire logic line_in,
	output logic line_oe_out
);
	initial begin
		line_oe_out = 1'b0;
	end

	// Idle, start bit, eight data bits lowest first, then the stop bit; only ever pulls low.
	// The stop bit is left after two cycles, because a prompt answer may begin inside it.
	task automatic send_byte(input logic [7:0] b);
		repeat (BIT_CYCLES) @(negedge ref_clk_in);
		line_oe_out = 1'b1;
		repeat (BIT_CYCLES) @(negedge ref_clk_in);
		for (int i = 0; i < 8; i++) begin
			line_oe_out = ~b[i];
			repeat (BIT_CYCLES) @(negedge ref_clk_in);
		end
		line_oe_out = 1'b0;
		repeat (2) @(negedge ref_clk_in);
	endtask : send_byte

	// Samples each bit near its centre; ok is the stop bit level, or 0 if no start came.
	task automatic recv_byte(input int wait_cyc, output logic [7:0] b, output logic ok);
		int n;
		n = 0;
		ok = 1'b0;
		b = 8'h00;
		while (line_in !== 1'b0 && n < wait_cyc) begin
			@(negedge ref_clk_in);
			n++;
		end
		if (line_in === 1'b0) begin
			repeat (BIT_CYCLES / 2) @(negedge ref_clk_in);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYCLES) @(negedge ref_clk_in);
				b[i] = line_in;
			end
			repeat (BIT_CYCLES) @(negedge ref_clk_in);
			ok = line_in;
		end
	endtask : recv_byte
endmodule : swcsm_host_model

// File: testbench/swcsm_top_tb.sv
// Self-checking bench for the single-wire message handler.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
	checked++; \
	if ((got) !== (ex)) begin \
		n_mismatch++; \
		$display("[ERR] %s expected %h seen %h", nm, ex, got); \
	end \
end
module swcsm_top_tb;
	localparam int BITC = 8;
	localparam int TOUT = 200;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic ce = 1'b0;
	logic sleep = 1'b0;
	logic restart = 1'b0;
	logic [7:0] fault0 = 8'h00;
	logic [6:0] fault1 = 7'h00;
	logic dut_out;
	logic dut_oe;
	logic host_oe;
	logic line;
	logic [7:0] cfg0;
	logic [7:0] cfg1;
	logic [7:0] cfg2;
	logic [7:0] status_register_zero;
	logic [7:0] status_register_one;
	int checked = 0;
	int n_mismatch = 0;
	int cyc = 0;
	logic [7:0] vals [9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'hFF};

	// The pull-up holds the line high unless some party pulls it low.
	assign line = (dut_oe ? dut_out : 1'b1) & ~host_oe;

	always #12.5 ref_clk = ~ref_clk;

	swcsm_top #(.BIT_CYCLES(BITC), .TIMEOUT_CYCLES(TOUT)) i_swcsm_top (
		.ref_clk_in(ref_clk), .rstn_in(rstn), .line_in(line), .line_out(dut_out),
		.line_oe_out(dut_oe), .chip_enable_in(ce), .sleep_mode_in(sleep),
		.restart_in(restart), .fault0_in(fault0), .fault1_in(fault1),
		.config_register_zero_out(cfg0), .current_ref_out(cfg1), .timing_cfg_out(cfg2),
		.status_register_zero_out(status_register_zero), .status_register_one_out(status_register_one));

	swcsm_host_model #(.BIT_CYCLES(BITC)) i_swcsm_host_model (
		.ref_clk_in(ref_clk), .line_in(line), .line_oe_out(host_oe));

	task automatic end_sim;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim

	task automatic get(input logic [7:0] e);
		logic [7:0] b;
		logic ok;
		i_swcsm_host_model.recv_byte(3 * TOUT, b, ok);
		`CHK("stop", 1'b1, ok)
		`CHK("byte", e, b)
	endtask : get

	// Confirms the line stays quiet for a while.
	task automatic none;
		logic [7:0] b;
		logic ok;
		i_swcsm_host_model.recv_byte(30 * BITC, b, ok);
		`CHK("quiet", 1'b0, ok)
	endtask : none

	task automatic rd(input logic [7:0] c, input logic [7:0] e1, input logic [7:0] e2);
		i_swcsm_host_model.send_byte(c);
		get(e1);
		get(e2);
	endtask : rd

	task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic [7:0] e1);
		i_swcsm_host_model.send_byte(c);
		i_swcsm_host_model.send_byte(d);
		get(e1);
	endtask : wr

	task automatic nack(input logic [7:0] c, input logic [7:0] e);
		i_swcsm_host_model.send_byte(c);
		get(e);
		none();
	endtask : nack

	// A hang is cut short well beyond the expected run length.
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			end_sim();
		end
	end

	initial begin
		repeat (3) @(negedge ref_clk);
		rstn = 1'b1;
		@(negedge ref_clk);
		`CHK("cfg0", 8'h00, cfg0)
		`CHK("cfg1", 8'h40, cfg1)
		`CHK("cfg2", 8'h00, cfg2)
		`CHK("status_register_one", 8'h01, status_register_one)
		none();
		rd(8'h82, 8'h42, 8'h00);
		foreach (vals[i]) begin
			wr(8'h81, vals[i], 8'h41);
			`CHK("cfg0", vals[i] & 8'h7F, cfg0)
		end
		rd(8'h82, 8'h42, 8'h7F);
		sleep = 1'b1;
		rd(8'h82, 8'h42, 8'h3F);
		sleep = 1'b0;
		wr(8'h83, 8'hA5, 8'h43);
		`CHK("cfg1", 8'hA5, cfg1)
		rd(8'h84, 8'h44, 8'hA5);
		wr(8'h87, 8'hFF, 8'h47);
		`CHK("cfg2", 8'h1F, cfg2)
		rd(8'h88, 8'h48, 8'h1F);
		nack(8'h89, 8'h09);
		nack(8'hA2, 8'h22);
		nack(8'h83, 8'h03);
		`CHK("cfg1", 8'hA5, cfg1)
		rd(8'h86, 8'h46, 8'h01);
		`CHK("status_register_one", 8'h00, status_register_one)
		fault0 = 8'h04;
		none();
		ce = 1'b1;
		// The power-up report was held back while chip enable was low, and it goes out first.
		get(8'h46);
		get(8'h00);
		get(8'h45);
		get(8'h04);
		fault0 = 8'h00;
		none();
		ce = 1'b0;
		repeat (4) @(negedge ref_clk);
		ce = 1'b1;
		repeat (4) @(negedge ref_clk);
		`CHK("status_register_zero", 8'h00, status_register_zero)
		fault0 = 8'h08;
		get(8'h45);
		get(8'h08);
		ce = 1'b0;
		rd(8'h85, 8'h45, 8'h08);
		`CHK("status_register_zero", 8'h08, status_register_zero)
		fault0 = 8'h00;
		rd(8'h85, 8'h45, 8'h08);
		`CHK("status_register_zero", 8'h00, status_register_zero)
		ce = 1'b1;
		restart = 1'b1;
		@(negedge ref_clk);
		restart = 1'b0;
		get(8'h46);
		get(8'h01);
		none();
		end_sim();
	end
endmodule : swcsm_top_tb
